// *** sceg_stack_ea.sv ***
`timescale 1ns/1ns
`include "sceg_map.svh"
module sceg_stack_ea
    import sceg_pkg::*;
#(
    parameter int PC_BITS = 23
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // limit register write
    input  wire logic        limit_wr,
    input  wire logic [15:0] limit_wdata,
    // stack request
    input  wire sceg_stk_t   stk_op,
    input  wire logic [PC_BITS-1:0] pc_val,
    input  wire logic [7:0]  status_low_byte,
    // operand request
    input  wire logic        op_valid,
    input  wire sceg_mode_t  op_mode,
    input  wire logic [3:0]  pointer_idx,
    input  wire logic [15:0] pointer_work_reg,
    input  wire logic [15:0] base_work_reg,
    input  wire logic [15:0] op_offset,
    input  wire logic [15:0] op_file_addr,
    input  wire logic        move_instr,
    input  wire logic        file_instr,
    input  wire logic        multiply_instr,
    input  wire logic        dest_is_work,
    // stack pointer view
    output logic [15:0]      stack_pointer_reg,
    output logic [15:0]      stack_limit_reg,
    // memory side
    output logic             mem_req,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic             mem_dbl,
    // register file side
    output logic             ptr_wr,
    output logic [3:0]       ptr_wr_idx,
    output logic [15:0]      ptr_wr_data,
    output logic [3:0]       result_idx,
    output logic             result_pair,
    output logic             result_to_mem,
    // exception side
    output logic             stack_err_trap
);
    // the pushed counter must leave bit 23 clear, so 23 bits at the most
    if (PC_BITS < 2 || PC_BITS > 23) begin : g_pc_bits_check
        $error("PC_BITS out of range");
    end

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [15:0] sp_q,  sp_d;
    logic [15:0] lim_q, lim_d;
    logic        trap_q;

    sceg_ea_if eif ();
    sceg_ea_calc u_calc (.e(eif));

    // --------------------------------------------------------------
    // stack arithmetic
    // --------------------------------------------------------------
    wire        is_push, is_pop, sp_op, err, ptr_is_sp;
    wire [15:0] sp_dec, sp_acc, ea_chk, ret_lo, ret_hi;
    wire [31:0] pc_ext;
    wire        over, under;
    assign is_push = (stk_op == SCEG_STK_PUSH) || (stk_op == SCEG_STK_EXC);
    assign is_pop  = (stk_op == SCEG_STK_POP);
    assign sp_dec  = sp_q - `SCEG_WORD_STEP;
    // push uses the free word itself
    assign sp_acc  = is_pop ? sp_dec : sp_q;
    assign ptr_is_sp = op_valid && (pointer_idx == `SCEG_SP_IDX)
                     && eif.addr_used && (op_mode != SCEG_FILE_DIRECT);
    // every stack pointer address is checked
    assign ea_chk = (stk_op != SCEG_STK_NONE) ? sp_acc : eif.ea;
    assign sp_op  = (stk_op != SCEG_STK_NONE) || ptr_is_sp;
    // strict greater, so push at limit passes
    assign over  = sp_op && (ea_chk > lim_q);
    assign under = sp_op && (ea_chk < `SCEG_UNDERFLOW_ADDR);
    assign err   = over || under;
    // zero extend, so bit 23 of the pushed pair stays clear
    assign pc_ext = {{(32-PC_BITS){1'b0}}, pc_val};
    assign ret_lo = pc_ext[15:0];
    // status low byte above the counter msb
    assign ret_hi = (stk_op == SCEG_STK_EXC)
                  ? {status_low_byte, pc_ext[23:16]}
                  : {8'h00, pc_ext[23:16]};

    // operand path to the calculator
    assign eif.mode       = op_mode;
    assign eif.ptr_val    = pointer_work_reg;
    assign eif.base_val   = base_work_reg;
    assign eif.offset     = op_offset;
    assign eif.file_addr  = op_file_addr;
    assign eif.move_instr = move_instr;

    // --------------------------------------------------------------
    // next values
    // --------------------------------------------------------------
    always_comb begin
        sp_d  = sp_q;
        lim_d = lim_q;
        if (limit_wr) begin
            lim_d = {limit_wdata[15:1], 1'b0};
        end
        if (!err) begin
            if (is_push) begin
                sp_d = sp_q + `SCEG_WORD_STEP;
            end else if (is_pop) begin
                sp_d = sp_dec;
            end else if (ptr_is_sp && eif.ptr_wr) begin
                sp_d = {eif.ptr_next[15:1], 1'b0};
            end
        end
    end

    // limit has no real reset value; zero keeps simulation tidy
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_q   <= `SCEG_UNDERFLOW_ADDR;
            lim_q  <= `SCEG_LIMIT_RESET;
            trap_q <= 1'b0;
        end else begin
            sp_q   <= sp_d;
            lim_q  <= lim_d;
            trap_q <= err;
        end
    end

    // --------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------
    logic        req_q, we_q, dbl_q, pw_q, pair_q, tomem_q;
    logic [15:0] addr_q, pwd_q;
    logic [31:0] wd_q;
    logic [3:0]  pidx_q, ridx_q;
    wire         op_wb;
    assign op_wb = op_valid && eif.ptr_wr && !err;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_q <= 1'b0;  we_q <= 1'b0;  dbl_q <= 1'b0;
            addr_q <= 16'h0000; wd_q <= 32'h0000_0000;
            pw_q <= 1'b0; pidx_q <= 4'h0; pwd_q <= 16'h0000;
            ridx_q <= 4'h0; pair_q <= 1'b0; tomem_q <= 1'b0;
        end else begin
            // offending access is not issued to memory
            req_q  <= !err && ((stk_op != SCEG_STK_NONE)
                     || (op_valid && eif.addr_used));
            we_q   <= is_push;
            dbl_q  <= is_push;
            addr_q <= (stk_op != SCEG_STK_NONE) ? sp_acc : eif.ea;
            wd_q   <= {ret_hi, ret_lo};
            pw_q   <= op_wb;
            pidx_q <= pointer_idx;
            pwd_q  <= eif.ptr_next;
            // file ops go to default register or file
            ridx_q <= file_instr ? `SCEG_DEFAULT_IDX : pointer_idx;
            pair_q <= multiply_instr;
            tomem_q <= !dest_is_work && !multiply_instr;
        end
    end
    assign mem_req           = req_q;
    assign mem_we            = we_q;
    assign mem_dbl           = dbl_q;
    assign mem_addr          = addr_q;
    assign mem_wdata         = wd_q;
    assign ptr_wr            = pw_q;
    assign ptr_wr_idx        = pidx_q;
    assign ptr_wr_data       = pwd_q;
    assign result_idx        = ridx_q;
    assign result_pair       = pair_q;
    assign result_to_mem     = tomem_q;
    assign stack_pointer_reg = sp_q;
    assign stack_limit_reg   = lim_q;
    assign stack_err_trap    = trap_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // stack results land on the edge after the request
    // pointer steps one word
    a_push_increments: assert property (
        (is_push && !err) |=> sp_q == $past(sp_q) + 16'h0002)
        else $error("push did not advance pointer");
    a_pop_decrements: assert property (
        (is_pop && !err) |=> sp_q == $past(sp_q) - 16'h0002)
        else $error("pop did not retreat pointer");
    a_limit_lsb_zero: assert property (
        stack_limit_reg[0] == 1'b0)
        else $error("limit lsb set");
    a_push_at_limit: assert property (
        (is_push && sp_q == lim_q && sp_q >= 16'h0800) |=> !stack_err_trap)
        else $error("push at limit trapped");
    a_push_over_limit: assert property (
        (is_push && sp_q > lim_q) |=> stack_err_trap)
        else $error("push over limit missed");
    a_underflow_trap: assert property (
        (is_pop && sp_q < 16'h0802) |=> stack_err_trap)
        else $error("underflow missed");
    a_trap_holds_sp: assert property (
        err |=> sp_q == $past(sp_q))
        else $error("pointer moved on error");
    // call word is the bare counter
    a_call_msb_clear: assert property (
        (stk_op == SCEG_STK_PUSH && !err) |=> mem_wdata == 32'($past(pc_val)))
        else $error("call push msb set");
    a_indirect_ea: assert property (
        (op_valid && op_mode == SCEG_INDIRECT && stk_op == SCEG_STK_NONE
         && !err) |=> mem_addr == $past(pointer_work_reg) && !ptr_wr)
        else $error("indirect address wrong");
    a_trap_one_cycle: assert property (
        stack_err_trap == $past(err))
        else $error("trap not one pulse per error");
    a_exc_status_hi: assert property (
        (stk_op == SCEG_STK_EXC && !err) |=> mem_wdata[31:23]
            == {$past(status_low_byte), 1'b0})
        else $error("exception push word wrong");
    a_err_no_request: assert property (
        err |=> !mem_req && !ptr_wr)
        else $error("refused access issued");
    a_sp_aligned: assert property (
        stack_pointer_reg[0] == 1'b0)
        else $error("stack pointer odd");
    a_file_near: assert property (
        (op_valid && op_mode == SCEG_FILE_DIRECT && !move_instr
         && stk_op == SCEG_STK_NONE) |=> mem_addr < `SCEG_NEAR_LIMIT)
        else $error("file address outside near space");
    a_post_modify: assert property (
        (op_valid && op_mode == SCEG_POST_MOD && stk_op == SCEG_STK_NONE
         && !err) |=> ptr_wr && mem_addr == $past(pointer_work_reg)
        && ptr_wr_data == $past(pointer_work_reg) + $past(op_offset))
        else $error("post modify wrong");
    a_pre_modify: assert property (
        (op_valid && op_mode == SCEG_PRE_MOD && stk_op == SCEG_STK_NONE
         && !err) |=> ptr_wr && mem_addr == ptr_wr_data
        && ptr_wr_data == $past(pointer_work_reg) + $past(op_offset))
        else $error("pre modify wrong");
    a_indexed_ea: assert property (
        (op_valid && op_mode == SCEG_INDEXED && stk_op == SCEG_STK_NONE
         && !err) |=> !ptr_wr
        && mem_addr == $past(pointer_work_reg) + $past(base_work_reg))
        else $error("indexed address wrong");
    a_lit_offset_ea: assert property (
        (op_valid && op_mode == SCEG_LIT_OFFSET && stk_op == SCEG_STK_NONE
         && !err) |=> !ptr_wr
        && mem_addr == $past(pointer_work_reg) + $past(op_offset))
        else $error("literal offset address wrong");
    a_file_default: assert property (
        file_instr |=> result_idx == `SCEG_DEFAULT_IDX)
        else $error("file op result register wrong");
    c_push: cover property (is_push && !err);
    c_pop: cover property (is_pop && !err);
    c_overflow: cover property (is_push && over);
    c_post_mod: cover property (op_valid && op_mode == SCEG_POST_MOD);
    c_exception: cover property (stk_op == SCEG_STK_EXC && !err);
endmodule // sceg_stack_ea

// *** sceg_map.svh ***
`ifndef SCEG_MAP_SVH
`define SCEG_MAP_SVH
// data space limits
`define SCEG_NEAR_BITS      13
`define SCEG_NEAR_LIMIT     16'h2000
`define SCEG_UNDERFLOW_ADDR 16'h0800
// stack word step in bytes
`define SCEG_WORD_STEP      16'h0002
// working register indices
`define SCEG_SP_IDX         4'hF
`define SCEG_DEFAULT_IDX    4'h0
// limit register reset value (undefined in hardware, chosen as zero)
`define SCEG_LIMIT_RESET    16'h0000
`endif

// *** sceg_pkg.sv ***
package sceg_pkg;
    // addressing modes
    typedef enum logic [2:0] {
        SCEG_FILE_DIRECT = 3'h0,
        SCEG_REG_DIRECT  = 3'h1,
        SCEG_INDIRECT    = 3'h3,
        SCEG_POST_MOD    = 3'h2,
        SCEG_PRE_MOD     = 3'h6,
        SCEG_INDEXED     = 3'h7,
        SCEG_LIT_OFFSET  = 3'h5
    } sceg_mode_t;
    // stack operations
    typedef enum logic [1:0] {
        SCEG_STK_NONE = 2'h0,
        SCEG_STK_PUSH = 2'h1,
        SCEG_STK_POP  = 2'h3,
        SCEG_STK_EXC  = 2'h2
    } sceg_stk_t;
endpackage

// *** sceg_ea_if.sv ***
`timescale 1ns/1ns
interface sceg_ea_if;
    import sceg_pkg::*;
    sceg_mode_t  mode;
    logic [15:0] ptr_val;
    logic [15:0] base_val;
    logic [15:0] offset;
    logic [15:0] file_addr;
    logic        move_instr;
    logic [15:0] ea;
    logic [15:0] ptr_next;
    logic        ptr_wr;
    logic        addr_used;
    modport calc (input mode, ptr_val, base_val, offset, file_addr,
                  move_instr, output ea, ptr_next, ptr_wr, addr_used);
    modport user (output mode, ptr_val, base_val, offset, file_addr,
                  move_instr, input ea, ptr_next, ptr_wr, addr_used);
endinterface

// *** sceg_ea_calc.sv ***
`timescale 1ns/1ns
`include "sceg_map.svh"
module sceg_ea_calc
    import sceg_pkg::*;
(
    sceg_ea_if.calc e
);
    // --------------------------------------------------------------
    // address forming
    // --------------------------------------------------------------
    wire [15:0] near_addr;
    wire [15:0] mod_val;
    wire [15:0] sum_idx;
    wire [15:0] sum_lit;
    // thirteen bit field; move reaches all space
    assign near_addr = e.move_instr ? e.file_addr
                     : {3'h0, e.file_addr[`SCEG_NEAR_BITS-1:0]};
    // signed offset adjusts the pointer for pre and post modes
    assign mod_val = e.ptr_val + e.offset;
    assign sum_idx = e.ptr_val + e.base_val;
    assign sum_lit = e.ptr_val + e.offset;
    // file direct; pre modify; indexed; literal offset; else the bare pointer
    assign e.ea = (e.mode == SCEG_FILE_DIRECT) ? near_addr
                : (e.mode == SCEG_PRE_MOD)     ? mod_val
                : (e.mode == SCEG_INDEXED)     ? sum_idx
                : (e.mode == SCEG_LIT_OFFSET)  ? sum_lit
                : e.ptr_val;
    assign e.ptr_wr   = (e.mode == SCEG_POST_MOD) || (e.mode == SCEG_PRE_MOD);
    assign e.ptr_next = mod_val;
    // register direct forms no address
    assign e.addr_used = (e.mode != SCEG_REG_DIRECT);
endmodule // sceg_ea_calc

// *** sceg_far_model.sv ***
`timescale 1ns/1ns
module sceg_far_model
    import sceg_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // bench preload of working registers
    input  wire logic        ld_en,
    input  wire logic [3:0]  ld_idx,
    input  wire logic [15:0] ld_data,
    // pointer read and write back
    input  wire logic [3:0]  pointer_idx,
    input  wire logic [15:0] stack_pointer_reg,
    input  wire logic        ptr_wr,
    input  wire logic [3:0]  ptr_wr_idx,
    input  wire logic [15:0] ptr_wr_data,
    output logic [15:0]      pointer_work_reg
);
    logic [15:0] rf_q [16];

    // index 15 is the stack pointer, owned by the block itself; a write
    // back still in flight is passed straight on, as a bypassed file would
    assign pointer_work_reg = (pointer_idx == 4'hF) ? stack_pointer_reg
                            : (ptr_wr && ptr_wr_idx == pointer_idx)
                            ? ptr_wr_data : rf_q[pointer_idx];

    // register file; a preload wins so the bench mirror stays exact
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 16; i++) rf_q[i] <= 16'h0000;
        end else if (ld_en) begin
            rf_q[ld_idx] <= ld_data;
        end else if (ptr_wr) begin
            rf_q[ptr_wr_idx] <= ptr_wr_data;
        end
    end
endmodule // sceg_far_model

// *** test_stack_check_and_ea_gen.sv ***
`timescale 1ns/1ns
module test_stack_check_and_ea_gen
    import sceg_pkg::*;
;
    typedef struct packed {
        logic t; logic sk; logic pw; logic we; logic pr; logic tm;
        logic [3:0] pi; logic [3:0] ri;
        logic [15:0] a; logic [31:0] wd; logic [15:0] pd; logic [15:0] sp;
    } sceg_exp_t;
    logic sys_clk = 1'h0, rst_b = 1'h0, limit_wr = 1'h0, op_valid = 1'h0;
    logic move_instr = 1'h0, file_instr = 1'h0, ld_en = 1'h0;
    logic multiply_instr = 1'h0, dest_is_work = 1'h0;
    logic [15:0] limit_wdata = 16'h0000, base_work_reg = 16'h0000;
    logic [15:0] op_offset = 16'h0000, op_file_addr = 16'h0000;
    logic [15:0] ld_data = 16'h0000, pointer_work_reg, sp_m, lim_m;
    logic [3:0]  pointer_idx = 4'h1, ld_idx = 4'h0;
    logic [22:0] pc_val = 23'h000000;
    logic [7:0]  status_low_byte = 8'h00;
    sceg_stk_t   stk_op = SCEG_STK_NONE;
    sceg_mode_t  op_mode = SCEG_INDIRECT;
    logic [15:0] stack_pointer_reg, stack_limit_reg, mem_addr, ptr_wr_data;
    logic [31:0] mem_wdata;
    logic [3:0]  ptr_wr_idx;
    logic mem_req, mem_we, mem_dbl, ptr_wr, result_pair, result_to_mem;
    logic stack_err_trap;
    logic [3:0]  result_idx;
    logic [15:0] pm [16];
    sceg_exp_t   expq [$];
    sceg_exp_t   e;
    int miscompares = 0, n_checks = 0, cyc = 0;
    sceg_mode_t  md [7] = '{SCEG_FILE_DIRECT, SCEG_REG_DIRECT, SCEG_INDIRECT,
        SCEG_POST_MOD, SCEG_PRE_MOD, SCEG_INDEXED, SCEG_LIT_OFFSET};

    sceg_stack_ea dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .limit_wr(limit_wr), .limit_wdata(limit_wdata), .stk_op(stk_op),
        .pc_val(pc_val), .status_low_byte(status_low_byte),
        .op_valid(op_valid), .op_mode(op_mode), .pointer_idx(pointer_idx),
        .pointer_work_reg(pointer_work_reg), .base_work_reg(base_work_reg),
        .op_offset(op_offset), .op_file_addr(op_file_addr),
        .move_instr(move_instr), .file_instr(file_instr),
        .multiply_instr(multiply_instr), .dest_is_work(dest_is_work),
        .stack_pointer_reg(stack_pointer_reg),
        .stack_limit_reg(stack_limit_reg), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_dbl(mem_dbl), .ptr_wr(ptr_wr), .ptr_wr_idx(ptr_wr_idx),
        .ptr_wr_data(ptr_wr_data), .result_idx(result_idx),
        .result_pair(result_pair), .result_to_mem(result_to_mem),
        .stack_err_trap(stack_err_trap));
    sceg_far_model far_u (.sys_clk(sys_clk), .rst_b(rst_b), .ld_en(ld_en),
        .ld_idx(ld_idx), .ld_data(ld_data), .pointer_idx(pointer_idx),
        .stack_pointer_reg(stack_pointer_reg), .ptr_wr(ptr_wr),
        .ptr_wr_idx(ptr_wr_idx), .ptr_wr_data(ptr_wr_data),
        .pointer_work_reg(pointer_work_reg));

    always #4 sys_clk = ~sys_clk;

    task automatic chk(input string n, input logic [31:0] x, s);
        n_checks++;
        if (s !== x) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task complete_run;
        if (expq.size() != 0) begin
            miscompares++;
            $display("Error pending expected 0 seen %0d", expq.size());
        end
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one request cycle; inputs move 1 ns after the edge
    task automatic step(input sceg_stk_t s, input logic lw, ov, le);
        stk_op = s; limit_wr = lw; op_valid = ov; ld_en = le;
        @(posedge sys_clk); #1;
    endtask
    task automatic stk(input sceg_stk_t o);
        e = '0; pc_val = 23'($urandom); status_low_byte = 8'($urandom);
        e.a = (o == SCEG_STK_POP) ? sp_m - 16'h0002 : sp_m;
        e.t = e.a > lim_m || e.a < 16'h0800;
        e.sk = 1'h1;
        e.we = o != SCEG_STK_POP;
        e.wd = {(o == SCEG_STK_EXC) ? status_low_byte : 8'h00, 1'h0,
                pc_val[22:16], pc_val[15:0]};
        if (!e.t) sp_m = (o == SCEG_STK_POP) ? e.a : sp_m + 16'h0002;
        e.sp = sp_m;
        expq.push_back(e);
        step(o, 1'h0, 1'h0, 1'h0);
    endtask
    task automatic opr(input sceg_mode_t m, input logic [3:0] i,
                       input logic mv, input logic [15:0] off);
        logic [15:0] p;
        e = '0; e.sp = sp_m; p = (i == 4'hF) ? sp_m : pm[i];
        base_work_reg = 16'($urandom); op_file_addr = 16'($urandom);
        case (m)
            SCEG_FILE_DIRECT: e.a = mv ? op_file_addr
                                       : {3'h0, op_file_addr[12:0]};
            SCEG_INDIRECT, SCEG_POST_MOD: e.a = p;
            SCEG_INDEXED: e.a = p + base_work_reg;
            default: e.a = p + off;
        endcase
        e.pd = p + off;
        e.t = i == 4'hF && m != SCEG_FILE_DIRECT
              && (e.a > lim_m || e.a < 16'h0800);
        e.pw = !e.t && (m == SCEG_POST_MOD || m == SCEG_PRE_MOD);
        if (e.pw) pm[i] = e.pd;
        op_mode = m; pointer_idx = i; op_offset = off; move_instr = mv;
        file_instr = (m == SCEG_FILE_DIRECT) && !mv;
        multiply_instr = 1'($urandom); dest_is_work = 1'($urandom);
        // file ops answer in the default register; multiply keeps a pair
        e.pi = i; e.ri = file_instr ? 4'h0 : i; e.pr = multiply_instr;
        e.tm = !dest_is_work && !multiply_instr;
        if (m != SCEG_REG_DIRECT) expq.push_back(e);
        step(SCEG_STK_NONE, 1'h0, 1'h1, 1'h0);
    endtask

    // results land one edge after the request; judged at the falling edge
    always @(negedge sys_clk) begin
        if (rst_b === 1'h1 && (mem_req === 1'h1 || stack_err_trap === 1'h1
                               || ptr_wr === 1'h1)) begin
            if (expq.size() == 0) chk("unexpected_result", 32'h0, 32'h1);
            else begin
                e = expq.pop_front();
                chk("stack_err_trap", e.t, stack_err_trap);
                chk("mem_req", !e.t, mem_req);
                if (!e.t) chk("mem_addr", e.a, mem_addr);
                if (!e.t) chk("mem_we", e.we, mem_we);
                if (!e.t) chk("mem_dbl", e.we, mem_dbl);
                if (!e.t && e.we) chk("mem_wdata", e.wd, mem_wdata);
                chk("ptr_wr", e.pw, ptr_wr);
                if (e.pw) chk("ptr_wr_data", e.pd, ptr_wr_data);
                if (e.pw) chk("ptr_wr_idx", e.pi, ptr_wr_idx);
                if (!e.sk) chk("result_idx", e.ri, result_idx);
                if (!e.sk) chk("result_pair", e.pr, result_pair);
                if (!e.sk) chk("result_to_mem", e.tm, result_to_mem);
                chk("stack_pointer_reg", e.sp, stack_pointer_reg);
            end
        end
    end
    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            complete_run;
        end
    end

    initial begin
        void'($urandom(32'h8ED8));
        sp_m = 16'h0800; lim_m = 16'h0000;
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1'h1;
        chk("stack_pointer_reg", 16'h0800, stack_pointer_reg);
        for (int k = 1; k < 15; k++) begin
            ld_idx = 4'(k); ld_data = 16'($urandom); pm[k] = ld_data;
            step(SCEG_STK_NONE, 1'h0, 1'h0, 1'h1);
        end
        limit_wdata = 16'h0807;
        step(SCEG_STK_NONE, 1'h1, 1'h0, 1'h0);
        lim_m = 16'h0806;
        chk("stack_limit_reg", lim_m, stack_limit_reg);
        // gap after a limit write before any stack access
        step(SCEG_STK_NONE, 1'h0, 1'h0, 1'h0);
        stk(SCEG_STK_POP);
        for (int k = 0; k < 5; k++) stk(k[0] ? SCEG_STK_EXC : SCEG_STK_PUSH);
        stk(SCEG_STK_POP);
        stk(SCEG_STK_POP);
        for (int k = 0; k < 21; k++)
            opr(md[k % 7], 4'($urandom_range(1, 14)), 1'h0,
                16'($urandom_range(0, 8)) * 16'h0002 - 16'h0008);
        opr(SCEG_LIT_OFFSET, 4'hF, 1'h0, 16'h0004);
        opr(SCEG_INDIRECT, 4'hF, 1'h0, 16'h0000);
        opr(SCEG_FILE_DIRECT, 4'h1, 1'h0, 16'h0000);
        opr(SCEG_FILE_DIRECT, 4'h1, 1'h1, 16'h0000);
        step(SCEG_STK_NONE, 1'h0, 1'h0, 1'h0);
        step(SCEG_STK_NONE, 1'h0, 1'h0, 1'h0);
        rst_b = 1'h0;
        @(posedge sys_clk); #1;
        chk("stack_pointer_reg", 16'h0800, stack_pointer_reg);
        chk("stack_limit_reg", 16'h0000, stack_limit_reg);
        rst_b = 1'h1;
        complete_run;
    end
endmodule // test_stack_check_and_ea_gen
